// File: design/rsa_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module rsa_top
  import rsa_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire rsa_bus_req_s bus_req,
  output logic [31:0]       rdata,
  input  wire logic         ref_clk_pin,
  output logic              alarm_irq,
  output logic              wake_req,
  output logic              rtc_running
);

  // ==========================================================================
  // Address decode
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  logic sel_div;
  logic sel_date_set;
  logic sel_time_set;
  logic sel_ctrl;
  logic sel_alm_date;
  logic sel_alm_time;
  logic sel_cur_date;
  logic sel_cur_time;
  logic sel_evt_raw;
  logic sel_evt_en;
  logic sel_evt_force;
  logic sel_evt_maskd;
  logic wr;
  logic rd;
  logic [31:0] wdata;

  assign wr            = bus_req.wr;
  assign rd            = bus_req.rd;
  assign wdata         = bus_req.wdata;
  assign sel_div       = reg_hit(bus_req.addr, RSA_OFF_DIVIDER);
  assign sel_date_set  = reg_hit(bus_req.addr, RSA_OFF_DATE_SET);
  assign sel_time_set  = reg_hit(bus_req.addr, RSA_OFF_TIME_SET);
  assign sel_ctrl      = reg_hit(bus_req.addr, RSA_OFF_CTRL);
  assign sel_alm_date  = reg_hit(bus_req.addr, RSA_OFF_ALM_DATE);
  assign sel_alm_time  = reg_hit(bus_req.addr, RSA_OFF_ALM_TIME);
  assign sel_cur_date  = reg_hit(bus_req.addr, RSA_OFF_CUR_DATE);
  assign sel_cur_time  = reg_hit(bus_req.addr, RSA_OFF_CUR_TIME);
  assign sel_evt_raw   = reg_hit(bus_req.addr, RSA_OFF_EVT_RAW);
  assign sel_evt_en    = reg_hit(bus_req.addr, RSA_OFF_EVT_EN);
  assign sel_evt_force = reg_hit(bus_req.addr, RSA_OFF_EVT_FORCE);
  assign sel_evt_maskd = reg_hit(bus_req.addr, RSA_OFF_EVT_MASKD);

  // ==========================================================================
  // Software registers
  logic [RSA_DIV_W-1:0] divider;
  rsa_time_s            setup;
  logic                 ctrl_enable;
  logic                 ctrl_noleap;
  rsa_time_s            alarm_cmp;
  logic                 global_match_enable;
  logic [6:0]           field_ena;
  logic                 evt_enable;
  logic                 evt_force;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divider <= RSA_DIV_RESET;
    end else if (wr && sel_div) begin
      divider <= wdata[RSA_DIV_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      setup <= RSA_TIME_RESET;
    end else if (wr && sel_date_set) begin
      setup.year  <= wdata[RSA_YEAR_LSB +: 12];
      setup.month <= wdata[RSA_MONTH_LSB +: 4];
      setup.day   <= wdata[RSA_DAY_LSB +: 5];
    end else if (wr && sel_time_set) begin
      setup.dotw <= wdata[RSA_DOTW_LSB +: 3];
      setup.hour <= wdata[RSA_HOUR_LSB +: 5];
      setup.min  <= wdata[RSA_MIN_LSB +: 6];
      setup.sec  <= wdata[RSA_SEC_LSB +: 6];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_enable <= 1'b0;
      ctrl_noleap <= 1'b0;
    end else if (wr && sel_ctrl) begin
      ctrl_enable <= wdata[RSA_CTRL_ENABLE];
      ctrl_noleap <= wdata[RSA_CTRL_NOLEAP];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alarm_cmp           <= RSA_TIME_RESET;
      global_match_enable <= 1'b0;
      field_ena           <= 7'h00;
    end else if (wr && sel_alm_date) begin
      alarm_cmp.year  <= wdata[RSA_YEAR_LSB +: 12];
      alarm_cmp.month <= wdata[RSA_MONTH_LSB +: 4];
      alarm_cmp.day   <= wdata[RSA_DAY_LSB +: 5];
      global_match_enable <= wdata[RSA_GLOBAL_MATCH_ENABLE];
      field_ena[6]    <= wdata[RSA_YEAR_ENA];
      field_ena[5]    <= wdata[RSA_MONTH_ENA];
      field_ena[4]    <= wdata[RSA_DAY_ENA];
    end else if (wr && sel_alm_time) begin
      alarm_cmp.dotw <= wdata[RSA_DOTW_LSB +: 3];
      alarm_cmp.hour <= wdata[RSA_HOUR_LSB +: 5];
      alarm_cmp.min  <= wdata[RSA_MIN_LSB +: 6];
      alarm_cmp.sec  <= wdata[RSA_SEC_LSB +: 6];
      field_ena[3]   <= wdata[RSA_DOTW_ENA];
      field_ena[2]   <= wdata[RSA_HOUR_ENA];
      field_ena[1]   <= wdata[RSA_MIN_ENA];
      field_ena[0]   <= wdata[RSA_SEC_ENA];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_enable <= 1'b0;
      evt_force  <= 1'b0;
    end else begin
      if (wr && sel_evt_en) begin
        evt_enable <= wdata[RSA_EVT_BIT];
      end
      if (wr && sel_evt_force) begin
        evt_force <= wdata[RSA_EVT_BIT];
      end
    end
  end

  // ==========================================================================
  // Reference pin synchroniser and edge detect
  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  logic ref_rise;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= ref_clk_pin;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  assign ref_rise = ref_sync & ~ref_prev;

  // ==========================================================================
  // Run state follows enable on reference edges
  rsa_run_e run_state;
  rsa_run_e next_run_state;

  always_comb begin
    next_run_state = run_state;
    case (run_state)
      RSA_STOPPED: begin
        if (ref_rise && ctrl_enable) begin
          next_run_state = RSA_RUNNING;
        end
      end
      RSA_RUNNING: begin
        if (ref_rise && !ctrl_enable) begin
          next_run_state = RSA_STOPPED;
        end
      end
      default: begin
        next_run_state = RSA_STOPPED;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_state <= RSA_STOPPED;
    end else begin
      run_state <= next_run_state;
    end
  end

  assign rtc_running = (run_state == RSA_RUNNING);

  // ==========================================================================
  // Load request, applied on the next reference edge
  logic load_req;
  logic next_load_req;
  logic load_now;
  logic load_set;

  assign load_set      = wr && sel_ctrl && wdata[RSA_CTRL_LOAD];
  assign load_now      = load_req & ref_rise;
  assign next_load_req = load_set | (load_req & ~ref_rise);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      load_req <= 1'b0;
    end else begin
      load_req <= next_load_req;
    end
  end

  // ==========================================================================
  // One-second divider
  logic [RSA_DIV_W-1:0] div_cnt;
  logic [RSA_DIV_W-1:0] next_div_cnt;
  logic                 div_done;
  logic                 sec_tick;

  assign div_done = (div_cnt >= divider);
  assign sec_tick = rtc_running & ref_rise & div_done & ~load_now;

  always_comb begin
    next_div_cnt = div_cnt;
    if (!rtc_running || load_now) begin
      next_div_cnt = '0;
    end else if (ref_rise) begin
      next_div_cnt = div_done ? '0 : RSA_DIV_W'(div_cnt + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ==========================================================================
  // Calendar counter
  rsa_time_s now;

  rsa_calendar u_calendar (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (sec_tick),
    .load     (load_now),
    .no_leap  (ctrl_noleap),
    .load_val (setup),
    .now      (now)
  );

  // ==========================================================================
  // Alarm match
  rsa_time_s cmp_mask;
  logic      match_hit;
  logic      evt_raw;
  logic      evt_masked;

  assign cmp_mask = {{12{field_ena[6]}}, {4{field_ena[5]}}, {5{field_ena[4]}},
                     {3{field_ena[3]}}, {5{field_ena[2]}}, {6{field_ena[1]}},
                     {6{field_ena[0]}}};
  assign match_hit = global_match_enable
                     & (((now ^ alarm_cmp) & cmp_mask) == '0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_raw <= 1'b0;
    end else begin
      evt_raw <= match_hit;
    end
  end

  assign evt_masked = (evt_raw & evt_enable) | evt_force;
  assign alarm_irq  = evt_masked;
  assign wake_req   = evt_masked;

  // ==========================================================================
  // Date capture on time read
  logic [11:0] snap_year;
  logic [3:0]  snap_month;
  logic [4:0]  snap_day;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      snap_year  <= 12'h000;
      snap_month <= 4'h0;
      snap_day   <= 5'h00;
    end else if (rd && sel_cur_time) begin
      snap_year  <= now.year;
      snap_month <= now.month;
      snap_day   <= now.day;
    end
  end

  // ==========================================================================
  // Read mux
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      if (sel_div) begin
        next_rdata[RSA_DIV_W-1:0] = divider;
      end else if (sel_date_set) begin
        next_rdata[RSA_YEAR_LSB +: 12] = setup.year;
        next_rdata[RSA_MONTH_LSB +: 4] = setup.month;
        next_rdata[RSA_DAY_LSB +: 5]   = setup.day;
      end else if (sel_time_set) begin
        next_rdata[RSA_DOTW_LSB +: 3] = setup.dotw;
        next_rdata[RSA_HOUR_LSB +: 5] = setup.hour;
        next_rdata[RSA_MIN_LSB +: 6]  = setup.min;
        next_rdata[RSA_SEC_LSB +: 6]  = setup.sec;
      end else if (sel_ctrl) begin
        next_rdata[RSA_CTRL_ENABLE] = ctrl_enable;
        next_rdata[RSA_CTRL_ACTIVE] = rtc_running;
        next_rdata[RSA_CTRL_NOLEAP] = ctrl_noleap;
      end else if (sel_alm_date) begin
        next_rdata[RSA_YEAR_LSB +: 12]  = alarm_cmp.year;
        next_rdata[RSA_MONTH_LSB +: 4]  = alarm_cmp.month;
        next_rdata[RSA_DAY_LSB +: 5]    = alarm_cmp.day;
        next_rdata[RSA_MATCH_ACTIVE]        = global_match_enable;
        next_rdata[RSA_GLOBAL_MATCH_ENABLE] = global_match_enable;
        next_rdata[RSA_YEAR_ENA]        = field_ena[6];
        next_rdata[RSA_MONTH_ENA]       = field_ena[5];
        next_rdata[RSA_DAY_ENA]         = field_ena[4];
      end else if (sel_alm_time) begin
        next_rdata[RSA_DOTW_LSB +: 3] = alarm_cmp.dotw;
        next_rdata[RSA_HOUR_LSB +: 5] = alarm_cmp.hour;
        next_rdata[RSA_MIN_LSB +: 6]  = alarm_cmp.min;
        next_rdata[RSA_SEC_LSB +: 6]  = alarm_cmp.sec;
        next_rdata[RSA_DOTW_ENA]      = field_ena[3];
        next_rdata[RSA_HOUR_ENA]      = field_ena[2];
        next_rdata[RSA_MIN_ENA]       = field_ena[1];
        next_rdata[RSA_SEC_ENA]       = field_ena[0];
      end else if (sel_cur_date) begin
        next_rdata[RSA_YEAR_LSB +: 12] = snap_year;
        next_rdata[RSA_MONTH_LSB +: 4] = snap_month;
        next_rdata[RSA_DAY_LSB +: 5]   = snap_day;
      end else if (sel_cur_time) begin
        next_rdata[RSA_DOTW_LSB +: 3] = now.dotw;
        next_rdata[RSA_HOUR_LSB +: 5] = now.hour;
        next_rdata[RSA_MIN_LSB +: 6]  = now.min;
        next_rdata[RSA_SEC_LSB +: 6]  = now.sec;
      end else if (sel_evt_raw) begin
        next_rdata[RSA_EVT_BIT] = evt_raw;
      end else if (sel_evt_en) begin
        next_rdata[RSA_EVT_BIT] = evt_enable;
      end else if (sel_evt_force) begin
        next_rdata[RSA_EVT_BIT] = evt_force;
      end else if (sel_evt_maskd) begin
        next_rdata[RSA_EVT_BIT] = evt_masked;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// File: design/rsa_pkg.sv
package rsa_pkg;

  // ==========================================================================
  // Register map
  localparam int        RSA_ADDR_W        = 8;
  localparam int        RSA_DATA_W        = 32;
  localparam logic [7:0] RSA_OFF_DIVIDER   = 8'h00;
  localparam logic [7:0] RSA_OFF_DATE_SET  = 8'h04;
  localparam logic [7:0] RSA_OFF_TIME_SET  = 8'h08;
  localparam logic [7:0] RSA_OFF_CTRL      = 8'h0C;
  localparam logic [7:0] RSA_OFF_ALM_DATE  = 8'h10;
  localparam logic [7:0] RSA_OFF_ALM_TIME  = 8'h14;
  localparam logic [7:0] RSA_OFF_CUR_DATE  = 8'h18;
  localparam logic [7:0] RSA_OFF_CUR_TIME  = 8'h1C;
  localparam logic [7:0] RSA_OFF_EVT_RAW   = 8'h20;
  localparam logic [7:0] RSA_OFF_EVT_EN    = 8'h24;
  localparam logic [7:0] RSA_OFF_EVT_FORCE = 8'h28;
  localparam logic [7:0] RSA_OFF_EVT_MASKD = 8'h2C;

  // ==========================================================================
  // Field positions
  localparam int RSA_YEAR_LSB      = 12;
  localparam int RSA_MONTH_LSB     = 8;
  localparam int RSA_DAY_LSB       = 0;
  localparam int RSA_DOTW_LSB      = 24;
  localparam int RSA_HOUR_LSB      = 16;
  localparam int RSA_MIN_LSB       = 8;
  localparam int RSA_SEC_LSB       = 0;
  localparam int RSA_CTRL_ENABLE   = 0;
  localparam int RSA_CTRL_ACTIVE   = 1;
  localparam int RSA_CTRL_LOAD     = 4;
  localparam int RSA_CTRL_NOLEAP   = 8;
  localparam int RSA_MATCH_ACTIVE  = 29;
  localparam int RSA_GLOBAL_MATCH_ENABLE = 28;
  localparam int RSA_YEAR_ENA      = 26;
  localparam int RSA_MONTH_ENA     = 25;
  localparam int RSA_DAY_ENA       = 24;
  localparam int RSA_DOTW_ENA      = 31;
  localparam int RSA_HOUR_ENA      = 30;
  localparam int RSA_MIN_ENA       = 29;
  localparam int RSA_SEC_ENA       = 28;
  localparam int RSA_EVT_BIT       = 0;

  // ==========================================================================
  // Widths, limits and reset values
  localparam int          RSA_DIV_W     = 16;
  localparam logic [15:0] RSA_DIV_RESET = 16'h0000;
  localparam logic [5:0]  RSA_SEC_MAX   = 6'h3B;
  localparam logic [5:0]  RSA_MIN_MAX   = 6'h3B;
  localparam logic [4:0]  RSA_HOUR_MAX  = 5'h17;
  localparam logic [2:0]  RSA_DOTW_MAX  = 3'h6;
  localparam logic [3:0]  RSA_MONTH_MAX = 4'hC;
  localparam logic [3:0]  RSA_FEB       = 4'h2;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [2:0]  dotw;
    logic [4:0]  hour;
    logic [5:0]  min;
    logic [5:0]  sec;
  } rsa_time_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rsa_bus_req_s;

  typedef enum logic {
    RSA_STOPPED = 1'b0,
    RSA_RUNNING = 1'b1
  } rsa_run_e;

  localparam rsa_time_s RSA_TIME_RESET = '0;

endpackage

// File: design/rsa_calendar.sv
`timescale 1ns/1ps
module rsa_calendar
  import rsa_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      tick,
  input  wire logic      load,
  input  wire logic      no_leap,
  input  wire rsa_time_s load_val,
  output rsa_time_s      now
);

  // ==========================================================================
  // Month length
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [11:0] y,
                                            input logic nl);
    case (m)
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
      4'h2:                   month_days = (y[1:0] == 2'h0 && !nl) ? 5'h1D : 5'h1C;
      default:                month_days = 5'h1F;
    endcase
  endfunction

  rsa_time_s next_now;
  logic      sec_wrap;
  logic      min_wrap;
  logic      hour_wrap;
  logic      day_wrap;
  logic      month_wrap;

  assign sec_wrap   = now.sec >= RSA_SEC_MAX;
  assign min_wrap   = now.min >= RSA_MIN_MAX;
  assign hour_wrap  = now.hour >= RSA_HOUR_MAX;
  assign day_wrap   = now.day >= month_days(now.month, now.year, no_leap);
  assign month_wrap = now.month >= RSA_MONTH_MAX;

  // ==========================================================================
  // Carry chain
  always_comb begin
    next_now = now;
    if (load) begin
      next_now = load_val;
    end else if (tick) begin
      next_now.sec = sec_wrap ? 6'h00 : 6'(now.sec + 6'h01);
      if (sec_wrap) begin
        next_now.min = min_wrap ? 6'h00 : 6'(now.min + 6'h01);
        if (min_wrap) begin
          next_now.hour = hour_wrap ? 5'h00 : 5'(now.hour + 5'h01);
          if (hour_wrap) begin
            next_now.dotw = (now.dotw >= RSA_DOTW_MAX) ? 3'h0 : 3'(now.dotw + 3'h1);
            next_now.day  = day_wrap ? 5'h01 : 5'(now.day + 5'h01);
            if (day_wrap) begin
              next_now.month = month_wrap ? 4'h1 : 4'(now.month + 4'h1);
              if (month_wrap) begin
                next_now.year = 12'(now.year + 12'h001);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      now <= RSA_TIME_RESET;
    end else begin
      now <= next_now;
    end
  end

endmodule

// File: dv/rsa_top_properties.sv
`timescale 1ns/1ps
module rsa_top_properties
  import rsa_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst_n,
  input wire rsa_bus_req_s bus_req,
  input wire logic [31:0]  rdata,
  input wire logic         ref_clk_pin,
  input wire logic         alarm_irq,
  input wire logic         wake_req,
  input wire logic         rtc_running
);
  // ====
  // Mirror of enable and force
  logic en_q;
  logic frc_q;
  wire  rd = bus_req.rd;
  wire  [7:0] a = bus_req.addr;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      frc_q <= 1'b0;
    end else if (bus_req.wr && a == RSA_OFF_EVT_EN) begin
      en_q <= bus_req.wdata[0];
    end else if (bus_req.wr && a == RSA_OFF_EVT_FORCE) begin
      frc_q <= bus_req.wdata[0];
    end
  end
  // ====
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wake; wake_req == alarm_irq; endproperty
  property p_idle; !rd |=> rdata == 32'h0; endproperty
  property p_unmap; rd && (a > RSA_OFF_EVT_MASKD || a[1:0] != 2'h0) |=> rdata == 32'h0;
  endproperty
  property p_div; rd && a == RSA_OFF_DIVIDER |=> rdata[31:16] == 16'h0; endproperty
  property p_date; rd && a == RSA_OFF_DATE_SET |=> (rdata & 32'hFF0000E0) == 32'h0;
  endproperty
  property p_time; rd && a == RSA_OFF_TIME_SET |=> (rdata & 32'hF8E0C0C0) == 32'h0;
  endproperty
  property p_gate; alarm_irq |-> en_q || frc_q; endproperty
  property p_force; frc_q |-> alarm_irq; endproperty
  property p_mask; rd && a == RSA_OFF_EVT_MASKD |=> rdata == {31'h0, $past(alarm_irq)};
  endproperty
  property p_match; rd && a == RSA_OFF_ALM_DATE |=> rdata[29] == rdata[28]; endproperty
  property p_run; rd && a == RSA_OFF_CTRL |=> rdata[1] == $past(rtc_running); endproperty
  a_wake: assert property (p_wake)
    else $error("wake differs from irq");
  a_idle: assert property (p_idle)
    else $error("read data without read");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_div: assert property (p_div)
    else $error("divider upper bits set");
  a_date: assert property (p_date)
    else $error("date reserved bits set");
  a_time: assert property (p_time)
    else $error("time reserved bits set");
  a_gate: assert property (p_gate)
    else $error("irq without enable");
  a_force: assert property (p_force)
    else $error("force not seen on irq");
  a_mask: assert property (p_mask)
    else $error("masked status differs");
  a_match: assert property (p_match)
    else $error("match active differs");
  a_run: assert property (p_run)
    else $error("running bit differs");
  c_irq: cover property ($rose(alarm_irq));
  c_run: cover property ($rose(rtc_running));
  c_pair: cover property ((rd && a == RSA_OFF_CUR_TIME) ##2 (rd && a == RSA_OFF_CUR_DATE));
endmodule
bind rsa_top rsa_top_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
  .ref_clk_pin(ref_clk_pin), .alarm_irq(alarm_irq), .wake_req(wake_req),
  .rtc_running(rtc_running)
);

// File: dv/tb_rsa_top.sv
`timescale 1ns/1ps
module tb_rsa_top
  import rsa_pkg::*;
;
  logic         core_clk;
  logic         rst_n;
  rsa_bus_req_s bus_req;
  logic [31:0]  rdata;
  logic         ref_clk_pin;
  logic         alarm_irq;
  logic         wake_req;
  logic         rtc_running;
  int           err_total;
  int           n_compared;
  int           cyc;
  int           yr, mo, dy, dw, hr, mi, se;
  logic [31:0]  rv;
  logic [31:0]  v;
  logic [7:0]   offs [5] = '{RSA_OFF_DIVIDER, RSA_OFF_DATE_SET, RSA_OFF_TIME_SET,
                             RSA_OFF_ALM_DATE, RSA_OFF_ALM_TIME};
  logic [31:0]  msk  [5] = '{32'h0000FFFF, 32'h00FFFF1F, 32'h071F3F3F,
                             32'h07FFFF1F, 32'hF71F3F3F};
  rsa_top u_dut (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .bus_req     (bus_req),
    .rdata       (rdata),
    .ref_clk_pin (ref_clk_pin),
    .alarm_irq   (alarm_irq),
    .wake_req    (wake_req),
    .rtc_running (rtc_running)
  );
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ====
  // Bus, checks and model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 rv = rdata;
    @(posedge core_clk);
    chk(rv, exp);
  endtask
  task automatic pulse();
    ref_clk_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    ref_clk_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  function automatic int mlen(int m, int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction
  task automatic adv();
    se++;
    if (se == 60) begin
      se = 0;
      mi++;
    end
    if (mi == 60) begin
      mi = 0;
      hr++;
    end
    if (hr == 24) begin
      hr = 0;
      dw = (dw + 1) % 7;
      dy++;
    end
    if (dy > mlen(mo, yr)) begin
      dy = 1;
      mo++;
    end
  endtask
  function automatic logic [31:0] tw();
    return 32'(dw) << 24 | 32'(hr) << 16 | 32'(mi) << 8 | 32'(se);
  endfunction
  function automatic logic [31:0] dwd();
    return 32'(yr) << 12 | 32'(mo) << 8 | 32'(dy);
  endfunction
  task automatic tick_chk();
    pulse();
    rdchk(RSA_OFF_CUR_TIME, tw());
    pulse();
    adv();
    rdchk(RSA_OFF_CUR_TIME, tw());
    rdchk(RSA_OFF_CUR_DATE, dwd());
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      close_out();
    end
  end
  // ====
  // Main sequence
  initial begin
    bus_req = '0;
    ref_clk_pin = 1'b0;
    rst_n = 1'b0;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    v = $urandom(16);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 48; a += 4) rdchk(8'(a), 32'h0);
    for (int i = 0; i < 5; i++) begin
      v = $urandom() & 32'hEFFFFFFF;
      wr(offs[i], v);
      rdchk(offs[i], v & msk[i]);
    end
    wr(RSA_OFF_ALM_DATE, 32'h10000000);
    rdchk(RSA_OFF_ALM_DATE, 32'h30000000);
    wr(RSA_OFF_ALM_DATE, 32'h0);
    wr(RSA_OFF_CTRL, 32'h110);
    rdchk(RSA_OFF_CTRL, 32'h100);
    wr(8'h30, v);
    rdchk(8'h30, 32'h0);
    rdchk(8'h05, 32'h0);
    wr(RSA_OFF_EVT_FORCE, 32'h1);
    chk(32'(wake_req), 32'h1);
    rdchk(RSA_OFF_EVT_MASKD, 32'h1);
    rdchk(RSA_OFF_EVT_RAW, 32'h0);
    wr(RSA_OFF_EVT_FORCE, 32'h0);
    chk(32'(alarm_irq), 32'h0);
    yr = 2024;
    mo = 2;
    dy = 28;
    dw = 6;
    hr = 23;
    mi = 59;
    se = 58;
    wr(RSA_OFF_DATE_SET, dwd());
    wr(RSA_OFF_TIME_SET, tw());
    wr(RSA_OFF_DIVIDER, 32'h1);
    wr(RSA_OFF_ALM_DATE, 32'h0);
    wr(RSA_OFF_ALM_TIME, 32'h10000000);
    wr(RSA_OFF_EVT_EN, 32'h1);
    wr(RSA_OFF_ALM_DATE, 32'h10000000);
    wr(RSA_OFF_CTRL, 32'h10);
    wr(RSA_OFF_CTRL, 32'h1);
    pulse();
    chk(32'(rtc_running), 32'h1);
    rdchk(RSA_OFF_CUR_TIME, tw());
    for (int k = 0; k < 3; k++) begin
      tick_chk();
      chk(32'(alarm_irq), 32'(se == 0));
    end
    while (se != 0) tick_chk();
    chk(32'(alarm_irq), 32'h1);
    wr(RSA_OFF_EVT_EN, 32'h0);
    chk(32'(alarm_irq), 32'h0);
    rdchk(RSA_OFF_EVT_RAW, 32'h1);
    wr(RSA_OFF_EVT_EN, 32'h1);
    wr(RSA_OFF_ALM_DATE, 32'h0);
    @(posedge core_clk);
    chk(32'(alarm_irq), 32'h0);
    wr(RSA_OFF_CTRL, 32'h0);
    pulse();
    chk(32'(rtc_running), 32'h0);
    close_out();
  end
endmodule
